//--- core/flash_ctrl_pkg.sv
package flash_ctrl_pkg;
   // register bus shape
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFF_CONTROL = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_KEY = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_PAGE = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_OFFSET = 5'h0C;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h10;
   localparam logic [ADDR_W-1:0] OFF_LATCH = 5'h14;
   // control word fields
   localparam int START_BIT = 15;
   localparam int PERMIT_BIT = 14;
   localparam int FAULT_BIT = 13;
   localparam int EEONLY_BIT = 12;
   localparam int ERASE_BIT = 6;
   localparam int OPC_W = 6;
   localparam logic CTRL_BIT_RESET = 1'b0;
   localparam logic [OPC_W-1:0] OPC_RESET = 6'h00;
   localparam logic [4:0] UNIMPL_BITS = 5'h00;
   // unlock key values
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   // operation codes
   localparam logic [OPC_W-1:0] OPC_ERASE4 = 6'h1A;
   localparam logic [OPC_W-1:0] OPC_ERASE2 = 6'h19;
   localparam logic [OPC_W-1:0] OPC_ERASE1 = 6'h18;
   localparam logic [3:0] PFX_BOOT = 4'hA;
   localparam logic [3:0] PFX_CHIP = 4'h9;
   localparam logic [3:0] PFX_CONFIG = 4'h5;
   localparam logic [3:0] PFX_EEPROM = 4'h4;
   localparam logic [3:0] PFX_GENERAL = 4'h3;
   localparam logic [3:0] PFX_PROGRAM = 4'h1;
   // operation kinds driven to the array
   localparam logic [2:0] KIND_NONE = 3'h0;
   localparam logic [2:0] KIND_ROW_ERASE = 3'h1;
   localparam logic [2:0] KIND_BOOT = 3'h2;
   localparam logic [2:0] KIND_CHIP = 3'h3;
   localparam logic [2:0] KIND_CONFIG = 3'h4;
   localparam logic [2:0] KIND_EEPROM = 3'h5;
   localparam logic [2:0] KIND_GENERAL = 3'h6;
   localparam logic [2:0] KIND_PROGRAM = 3'h7;
   localparam logic [2:0] ROWS_1 = 3'h1;
   localparam logic [2:0] ROWS_2 = 3'h2;
   localparam logic [2:0] ROWS_4 = 3'h4;
   // rows are edge aligned: masks for 1, 2 and 4 rows
   localparam logic [23:0] MASK_1ROW = 24'hFFFFC0;
   localparam logic [23:0] MASK_2ROW = 24'hFFFF80;
   localparam logic [23:0] MASK_4ROW = 24'hFFFF00;
   // holding latches: one row of instructions
   localparam int LATCH_AW = 5;
   localparam int LATCH_DW = 24;
   localparam logic [LATCH_AW-1:0] LAST_WORD = 5'h1F;
   // self-timed durations
   localparam int TIMER_W = 24;
   localparam int CLK_PERIOD_NS = 20;
   localparam int ERASE_TIME_US = 3000;
   localparam int PROGRAM_TIME_US = 2000;
   localparam logic [TIMER_W-1:0] ERASE_CYCLES_DEF =
      TIMER_W'(ERASE_TIME_US * 1000 / CLK_PERIOD_NS);
   localparam logic [TIMER_W-1:0] PROGRAM_CYCLES_DEF =
      TIMER_W'(PROGRAM_TIME_US * 1000 / CLK_PERIOD_NS);
   localparam logic [TIMER_W-1:0] TIMER_ONE = 24'h000001;
   // state encodings
   typedef enum logic [2:0] {
      KEY_IDLE = 3'b001,
      KEY_HALF = 3'b010,
      KEY_OPEN = 3'b100
   } key_state_type;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_LOAD = 4'b0010,
      ST_RUN = 4'b0100,
      ST_RESP = 4'b1000
   } ctl_state_type;
endpackage

//--- core/holding_latch.sv
`timescale 1ns/100ps
// one row of program words waiting to be committed
module holding_latch import flash_ctrl_pkg::*; (
   input wire logic core_clk,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic [LATCH_AW-1:0] wr_addr,
   input wire logic [LATCH_DW-1:0] wr_data,
   input wire logic [LATCH_AW-1:0] rd_addr,
   output logic [LATCH_DW-1:0] rd_data
);
   logic [LATCH_DW-1:0] mem [0:(1<<LATCH_AW)-1];

   // write port and registered read port
   always_ff @(posedge core_clk) begin
      if (ce) begin
         if (wr_en) begin
            mem[wr_addr] <= wr_data;
         end
         rd_data <= mem[rd_addr];
      end
   end
endmodule

//--- core/flash_program_erase_control.sv
`timescale 1ns/100ps
// Notes on behaviour
// - the key register is write only and reads as zero.
// - the processor stays stalled while an operation runs.
// - bit 15 launches the operation; hardware clears it when done.
// - software only sets bit 15; zero means nothing is active.
// - bit 14 permits operations; zero inhibits them all.
// - bit 13 flags a bad start; a good start leaves it zero.
// - bit 6 picks erase when one, program when zero.
// - erase codes 011010, 011001, 011000 erase four, two, one rows.
// - 1010xx boot block, 1001xx all memory, 0101xx configuration erase.
// - 0100xx erases data EEPROM, 0011xx erases general block.
// - boot and full erase only in external programming mode.
// - program codes 0001xx write one row from the latches.
// - any other code does nothing when started.
// - the table pointer picks the rows erased or programmed.
// - control bits 11 to 7 read zero.
// - bit 12 only matters for data EEPROM work; the code only stores it and reads it back, and no operation uses it.
// - after unlock only the next bus write may start an operation.
// - latch writes land in holding latches until programming.
module flash_program_erase_control import flash_ctrl_pkg::*; #(
   parameter logic [TIMER_W-1:0] ERASE_CYCLES = ERASE_CYCLES_DEF,
   parameter logic [TIMER_W-1:0] PROGRAM_CYCLES = PROGRAM_CYCLES_DEF
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic external_programming_mode,
   output logic cpu_stall,
   output logic flash_go,
   output logic [2:0] flash_kind,
   output logic [2:0] flash_rows,
   output logic [23:0] flash_addr,
   output logic flash_wvalid,
   output logic [LATCH_AW-1:0] flash_windex,
   output logic [LATCH_DW-1:0] flash_wdata
);
   // control register fields
   logic start_reg, permit_reg, fault_reg, eeonly_reg, erase_reg;
   logic [OPC_W-1:0] opc_reg;
   logic [7:0] page_reg;
   logic [15:0] offset_reg;
   key_state_type key_state_reg;
   ctl_state_type state_reg;
   logic [TIMER_W-1:0] timer_reg;
   logic [LATCH_AW-1:0] idx_reg, windex_reg;
   logic mode_meta_reg, mode_sync_reg;
   logic wait_reg, stall_reg, go_reg, wvalid_reg;
   logic [2:0] kind_reg, rows_reg;
   logic [23:0] addr_reg;
   logic [DATA_W-1:0] rdata_reg;

   // bus request decode
   wire take = ce && state_reg == ST_IDLE && (avs_read || avs_write);
   wire wr_take = take && avs_write;
   wire rd_take = take && avs_read;
   wire hit_ctrl = avs_address == OFF_CONTROL;
   wire hit_key = avs_address == OFF_KEY;
   wire hit_page = avs_address == OFF_PAGE;
   wire hit_offset = avs_address == OFF_OFFSET;
   wire hit_status = avs_address == OFF_STATUS;
   wire hit_latch = avs_address == OFF_LATCH;
   wire be_lo = avs_byteenable[0];
   wire be_hi = avs_byteenable[1];
   wire wr_ctrl = wr_take && hit_ctrl;
   wire unlocked = key_state_reg == KEY_OPEN;

   // values the control register holds after this write
   wire new_permit = (wr_ctrl && be_hi) ? avs_writedata[PERMIT_BIT]
      : permit_reg;
   wire new_erase = (wr_ctrl && be_lo) ? avs_writedata[ERASE_BIT]
      : erase_reg;
   wire [OPC_W-1:0] new_opc = (wr_ctrl && be_lo)
      ? avs_writedata[OPC_W-1:0] : opc_reg;
   wire [3:0] pfx = new_opc[5:2];

   wire row_code = new_opc == OPC_ERASE4 || new_opc == OPC_ERASE2
      || new_opc == OPC_ERASE1;
   wire [2:0] erase_kind = row_code ? KIND_ROW_ERASE
      : pfx == PFX_BOOT ? KIND_BOOT
      : pfx == PFX_CHIP ? KIND_CHIP
      : pfx == PFX_CONFIG ? KIND_CONFIG
      : pfx == PFX_EEPROM ? KIND_EEPROM
      : pfx == PFX_GENERAL ? KIND_GENERAL : KIND_NONE;
   wire [2:0] prog_kind = pfx == PFX_PROGRAM ? KIND_PROGRAM : KIND_NONE;
   wire [2:0] kind_dec = new_erase ? erase_kind : prog_kind;
   wire [2:0] rows_dec = (new_opc == OPC_ERASE4) ? ROWS_4
      : (new_opc == OPC_ERASE2) ? ROWS_2 : ROWS_1;

   // edge aligned row address from the table pointer
   wire [23:0] table_addr = {page_reg, offset_reg};
   wire [23:0] row_mask = (kind_dec == KIND_ROW_ERASE && rows_dec == ROWS_4)
      ? MASK_4ROW
      : (kind_dec == KIND_ROW_ERASE && rows_dec == ROWS_2) ? MASK_2ROW
      : MASK_1ROW;
   wire [23:0] row_addr = table_addr & row_mask;

   // protected erases need external programming mode
   wire prot_kind = kind_dec == KIND_BOOT || kind_dec == KIND_CHIP;
   // start accepted only when unlocked and permitted
   wire start_try = wr_ctrl && be_hi && avs_writedata[START_BIT];
   wire start_ok = start_try && unlocked && new_permit
      && !(prot_kind && !mode_sync_reg);
   wire start_bad = start_try && !start_ok;
   // a defined code runs, anything else completes at once
   wire start_run = start_ok && kind_dec != KIND_NONE;
   wire run_done = state_reg == ST_RUN && timer_reg == '0;
   wire load_last = state_reg == ST_LOAD && idx_reg == LAST_WORD;

   // latch write lands at the word picked by the table offset
   wire latch_we = wr_take && hit_latch;
   wire [LATCH_AW-1:0] latch_waddr = offset_reg[LATCH_AW:1];
   wire [15:0] offset_inc = offset_reg + 16'h0002;

   wire [15:0] ctrl_word = {start_reg, permit_reg, fault_reg,
      eeonly_reg, UNIMPL_BITS, erase_reg, opc_reg};
   wire [DATA_W-1:0] status_word = {29'h00000000, mode_sync_reg,
      key_state_reg == KEY_HALF, unlocked};
   // key and latch registers read as zero
   wire [DATA_W-1:0] rd_mux = hit_ctrl ? {16'h0000, ctrl_word}
      : hit_page ? {24'h000000, page_reg}
      : hit_offset ? {16'h0000, offset_reg}
      : hit_status ? status_word : 32'h00000000;

   // mode pin passes two flip-flops before use
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mode_meta_reg <= 1'b0;
         mode_sync_reg <= 1'b0;
      end else if (ce) begin
         mode_meta_reg <= external_programming_mode;
         mode_sync_reg <= mode_meta_reg;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         key_state_reg <= KEY_IDLE;
      end else if (wr_take) begin
         if (hit_key && be_lo && avs_writedata[7:0] == KEY_FIRST) begin
            key_state_reg <= KEY_HALF;
         end else if (hit_key && be_lo && key_state_reg == KEY_HALF
               && avs_writedata[7:0] == KEY_SECOND) begin
            key_state_reg <= KEY_OPEN;
         end else begin
            key_state_reg <= KEY_IDLE;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         permit_reg <= CTRL_BIT_RESET;
         eeonly_reg <= CTRL_BIT_RESET;
         erase_reg <= CTRL_BIT_RESET;
         opc_reg <= OPC_RESET;
      end else if (wr_ctrl) begin
         permit_reg <= new_permit;
         erase_reg <= new_erase;
         opc_reg <= new_opc;
         if (be_hi) begin
            eeonly_reg <= avs_writedata[EEONLY_BIT];
         end
      end
   end

   // fault flag: a bad start sets it over any clear
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         fault_reg <= CTRL_BIT_RESET;
      end else if (start_bad) begin
         fault_reg <= 1'b1;
      end else if (start_ok) begin
         fault_reg <= 1'b0;
      end else if (wr_ctrl && be_hi) begin
         fault_reg <= avs_writedata[FAULT_BIT];
      end
   end

   // table pointer registers, offset steps after each latch write
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         page_reg <= 8'h00;
         offset_reg <= 16'h0000;
      end else if (wr_take && hit_page && be_lo) begin
         page_reg <= avs_writedata[7:0];
      end else if (wr_take && hit_offset) begin
         offset_reg <= avs_writedata[15:0];
      end else if (latch_we) begin
         offset_reg <= offset_inc;
      end
   end

   // start bit set on launch, cleared only by hardware
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         start_reg <= CTRL_BIT_RESET;
      end else if (start_run && take) begin
         start_reg <= 1'b1;
      end else if (ce && run_done) begin
         start_reg <= 1'b0;
      end
   end

   // sequencer: answer, stream latches, time the operation
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
         timer_reg <= '0;
         idx_reg <= '0;
         wait_reg <= 1'b1;
         stall_reg <= 1'b0;
      end else if (ce) begin
         unique case (state_reg)
            ST_IDLE: begin
               if (take && start_run && kind_dec == KIND_PROGRAM) begin
                  state_reg <= ST_LOAD;
                  idx_reg <= '0;
                  stall_reg <= 1'b1;
               end else if (take && start_run) begin
                  state_reg <= ST_RUN;
                  timer_reg <= ERASE_CYCLES - TIMER_ONE;
                  stall_reg <= 1'b1;
               end else if (take) begin
                  state_reg <= ST_RESP;
                  wait_reg <= 1'b0;
               end
            end
            ST_LOAD: begin
               idx_reg <= idx_reg + 5'h01;
               if (load_last) begin
                  state_reg <= ST_RUN;
                  timer_reg <= PROGRAM_CYCLES - TIMER_ONE;
               end
            end
            // stall held until the timer expires
            ST_RUN: begin
               if (run_done) begin
                  state_reg <= ST_RESP;
                  wait_reg <= 1'b0;
                  stall_reg <= 1'b0;
               end else begin
                  timer_reg <= timer_reg - TIMER_ONE;
               end
            end
            ST_RESP: begin
               state_reg <= ST_IDLE;
               wait_reg <= 1'b1;
            end
         endcase
      end
   end

   // array command and latch streaming outputs
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         go_reg <= 1'b0;
         kind_reg <= KIND_NONE;
         rows_reg <= ROWS_1;
         addr_reg <= 24'h000000;
         wvalid_reg <= 1'b0;
         windex_reg <= '0;
         rdata_reg <= 32'h00000000;
      end else if (ce) begin
         go_reg <= take && start_run;
         wvalid_reg <= state_reg == ST_LOAD;
         windex_reg <= idx_reg;
         if (take && start_run) begin
            kind_reg <= kind_dec;
            rows_reg <= rows_dec;
            addr_reg <= row_addr;
         end
         if (rd_take) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   holding_latch latch_mem (
      .core_clk(core_clk),
      .ce(ce),
      .wr_en(latch_we),
      .wr_addr(latch_waddr),
      .wr_data(avs_writedata[LATCH_DW-1:0]),
      .rd_addr(idx_reg),
      .rd_data(flash_wdata)
   );

   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign cpu_stall = stall_reg;
   assign flash_go = go_reg;
   assign flash_kind = kind_reg;
   assign flash_rows = rows_reg;
   assign flash_addr = addr_reg;
   assign flash_wvalid = wvalid_reg;
   assign flash_windex = windex_reg;

   // helper: cycles spent with the start bit set
   logic [TIMER_W:0] busy_cnt;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         busy_cnt <= '0;
      end else if (ce) begin
         busy_cnt <= start_reg ? busy_cnt + 25'h0000001 : '0;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   a_locked_start_refused: assert property (
      ce && start_try && !unlocked |=> fault_reg && !start_reg)
      else $error("start accepted without unlock");
   a_key_reads_zero: assert property (
      ce && rd_take && hit_key |=> !avs_waitrequest && avs_readdata == '0)
      else $error("key register returned data");
   a_stall_while_busy: assert property (
      start_reg |-> cpu_stall && avs_waitrequest)
      else $error("bus answered during operation");
   a_start_bounded: assert property (
      busy_cnt <= {1'b0, ERASE_CYCLES} + {1'b0, PROGRAM_CYCLES} + 25'h40)
      else $error("start bit never cleared");
   a_start_hw_clear: assert property (
      $fell(start_reg) |-> $past(state_reg) == ST_RUN && !avs_waitrequest)
      else $error("start bit cleared outside completion");
   a_permit_inhibits: assert property (
      ce && start_try && !new_permit |=> !start_reg && !flash_go && fault_reg)
      else $error("operation ran while inhibited");
   a_fault_good_start: assert property (
      ce && take && start_ok |=> !fault_reg)
      else $error("fault left set after good start");
   a_row_erase_go: assert property (
      ce && take && start_run && kind_dec == KIND_ROW_ERASE
      |=> flash_go && flash_kind == KIND_ROW_ERASE && cpu_stall)
      else $error("row erase not launched");
   a_protected_mode: assert property (
      flash_go && (flash_kind == KIND_BOOT || flash_kind == KIND_CHIP)
      |-> $past(mode_sync_reg))
      else $error("protected erase outside external mode");
   a_program_streams: assert property (
      flash_go && flash_kind == KIND_PROGRAM && ce |=> flash_wvalid)
      else $error("program did not stream latches");
   a_row_aligned: assert property (
      flash_go && flash_kind == KIND_ROW_ERASE |-> flash_addr[5:0] == 6'h00)
      else $error("row address not aligned");
   a_unimpl_zero: assert property (
      ce && rd_take && hit_ctrl |=> avs_readdata[11:7] == 5'h00)
      else $error("unimplemented bits read nonzero");
   a_unlock_once: assert property (
      ce && wr_take && unlocked |=> key_state_reg != KEY_OPEN)
      else $error("unlock survived a write");
endmodule

//--- bench/tb.sv
`timescale 1ns/100ps
module tb import flash_ctrl_pkg::*;;
   logic core_clk = 1'b0, rstn = 1'b0, ce = 1'b1, ext_mode = 1'b0;
   logic avs_read = 1'b0, avs_write = 1'b0;
   logic [ADDR_W-1:0] avs_address = 5'h00;
   logic [DATA_W-1:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [3:0] avs_byteenable = 4'hF;
   logic avs_waitrequest, cpu_stall, flash_go, flash_wvalid;
   logic [2:0] flash_kind, flash_rows;
   logic [23:0] flash_addr;
   logic [LATCH_AW-1:0] flash_windex;
   logic [LATCH_DW-1:0] flash_wdata;
   int mismatches = 0, samples_checked = 0, go_cnt = 0, w_cnt = 0;
   int stall_cnt = 0, cyc = 0, seed = 32'h4D4E03FB;
   // short self-timed durations for the bench
   localparam int ERASE_N = 20;
   localparam int PROG_N = 10;
   logic [7:0] page_m;
   logic [15:0] off_m;
   logic [23:0] lat_m [32];
   // erase table: control word, kind, rows, refused
   logic [15:0] tc [12] = '{16'hC05A, 16'hC059, 16'hD058, 16'hC054,
      16'hC050, 16'hC04C, 16'hC068, 16'hC064, 16'hC05B, 16'hC018,
      16'hC068, 16'hC064};
   logic [2:0] tk [12] = '{3'h1, 3'h1, 3'h1, 3'h4, 3'h5, 3'h6, 3'h0,
      3'h0, 3'h0, 3'h0, 3'h2, 3'h3};
   logic [2:0] tr [12] = '{3'h4, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1,
      3'h1, 3'h1, 3'h1, 3'h1, 3'h1};
   logic [11:0] tbad = 12'h0C0;

   flash_program_erase_control #(
      .ERASE_CYCLES(24'(ERASE_N)),
      .PROGRAM_CYCLES(24'(PROG_N))
   ) u_dut (
      .core_clk(core_clk), .rstn(rstn), .ce(ce),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .external_programming_mode(ext_mode), .cpu_stall(cpu_stall),
      .flash_go(flash_go), .flash_kind(flash_kind),
      .flash_rows(flash_rows), .flash_addr(flash_addr),
      .flash_wvalid(flash_wvalid), .flash_windex(flash_windex),
      .flash_wdata(flash_wdata)
   );

   // 50 MHz clock
   initial begin
      forever #10 core_clk = ~core_clk;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %0h seen %0h", n, e, g);
      end
   endtask

   // one bus access: hold until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] rdat);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      rdat = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      logic [31:0] v;
      bus(1'b0, a, 32'h0, v);
      chk("read", e, v);
   endtask

   // optional unlock, start write, then compare with the model
   task automatic op(input logic [15:0] c, input logic key,
                     input logic [2:0] k, input logic [2:0] r,
                     input logic bad);
      int g0, n;
      logic [23:0] m;
      g0 = go_cnt;
      stall_cnt = 0;
      if (key) begin
         bus(1'b1, OFF_KEY, 32'h55, q);
         bus(1'b1, OFF_KEY, 32'hAA, q);
      end
      bus(1'b1, OFF_CONTROL, {16'h0, c}, q);
      rd(OFF_CONTROL, {16'h0, (bad ? c | 16'h2000 : c) & 16'h707F});
      chk("launches", 32'(k != KIND_NONE), 32'(go_cnt - g0));
      n = (k == KIND_NONE) ? 0 : (k == KIND_PROGRAM) ? 32 + PROG_N : ERASE_N;
      chk("stall", 32'(n), 32'(stall_cnt));
      if (k != KIND_NONE) begin
         m = (r == ROWS_4) ? MASK_4ROW : (r == ROWS_2) ? MASK_2ROW :
            MASK_1ROW;
         chk("kind", 32'(k), 32'(flash_kind));
         if (k == KIND_ROW_ERASE)
            chk("rows", 32'(r), 32'(flash_rows));
         if (k == KIND_ROW_ERASE || k == KIND_PROGRAM)
            chk("addr", 32'({page_m, off_m} & m), 32'(flash_addr));
      end
   endtask

   // count launches and stall cycles, check streamed words, cut hangs
   always @(posedge core_clk) begin
      cyc++;
      if (cpu_stall === 1'b1)
         stall_cnt++;
      if (flash_go === 1'b1)
         go_cnt++;
      if (flash_wvalid === 1'b1) begin
         w_cnt++;
         chk("latch word", 32'(lat_m[flash_windex]), 32'(flash_wdata));
      end
      if (cyc == 5000) begin
         mismatches++;
         give_verdict();
      end
   end

   initial begin
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      // reset state, write-only key and an unmapped hole
      rd(OFF_CONTROL, 32'h0);
      bus(1'b1, OFF_KEY, 32'h55, q);
      rd(OFF_KEY, 32'h0);
      rd(OFF_STATUS, 32'h2);
      rd(5'h1C, 32'h0);
      page_m = 8'($random(seed));
      off_m = 16'($random(seed));
      bus(1'b1, OFF_PAGE, {24'h0, page_m}, q);
      bus(1'b1, OFF_OFFSET, {16'h0, off_m}, q);
      // start refused when locked, unlock already used or permit bit clear
      op(16'hC058, 1'b0, KIND_NONE, ROWS_1, 1'b1);
      op(16'hC058, 1'b1, KIND_ROW_ERASE, ROWS_1, 1'b0);
      op(16'hC058, 1'b0, KIND_NONE, ROWS_1, 1'b1);
      op(16'h8058, 1'b1, KIND_NONE, ROWS_1, 1'b1);
      // wrong key, then a foreign write inside the unlock
      bus(1'b1, OFF_KEY, 32'h55, q);
      bus(1'b1, OFF_KEY, 32'h5A, q);
      op(16'hC058, 1'b0, KIND_NONE, ROWS_1, 1'b1);
      bus(1'b1, OFF_KEY, 32'h55, q);
      bus(1'b1, OFF_PAGE, {24'h0, page_m}, q);
      bus(1'b1, OFF_KEY, 32'hAA, q);
      op(16'hC058, 1'b0, KIND_NONE, ROWS_1, 1'b1);
      bus(1'b1, OFF_CONTROL, 32'h0F80, q);
      rd(OFF_CONTROL, 32'h0);
      // every erase code, undefined and protected
      for (int i = 0; i < 12; i++) begin
         if (i == 10)
            ext_mode <= 1'b1;
         op(tc[i], 1'b1, tk[i], tr[i], tbad[i]);
      end
      // fill the holding row, then program it
      for (int i = 0; i < 32; i++) begin
         lat_m[off_m[5:1]] = 24'($random(seed));
         bus(1'b1, OFF_LATCH, {8'h0, lat_m[off_m[5:1]]}, q);
         off_m = off_m + 16'h0002;
      end
      w_cnt = 0;
      op(16'hC004, 1'b1, KIND_PROGRAM, ROWS_1, 1'b0);
      chk("words", 32'h20, 32'(w_cnt));
      give_verdict();
   end
endmodule
